// ===== tmr_pkg.sv
// How it works
// - Software reads and writes the 8-bit count register; it holds every mode's value.
// - Timer mode with no prescaler advances the count once per instruction cycle.
// - A software write to the count stops counting for two instruction cycles.
// - Pin counting needs clock source, comparator source and output enable bits set.
// - Edge select zero counts rising pin edges, one counts falling pin edges.
// - Clock source set, comparator source clear: count comparator output, enable ignored.
// - The one prescaler feeds either this counter or the watchdog, never both.
// - Assignment bit zero routes prescaler to counter, one routes it to watchdog.
// - The prescaler is an 8-bit counter with a software rate setting.
// - Software can neither read nor load the prescaler count.
// - Assigned to the counter, the prescaler divides by powers of two, 2 to 256.
// - Count writes clear the prescaler while it is assigned; reset clears it too.
// - Assignment bit and three-bit rate field set routing and division ratio.
package tmr_pkg;

	localparam int COUNT_WIDTH = 8;
	localparam int PRE_WIDTH = 8;
	localparam int RATE_WIDTH = 3;
	localparam int INSTR_DIV_DEFAULT = 4;

	// Register indices, byte address is four times the index
	localparam logic [5:0] IDX_COUNT = 6'h01;
	localparam logic [5:0] IDX_CMP_CTRL = 6'h08;
	localparam logic [5:0] IDX_CONFIG = 6'h10;

	// Configuration register fields
	localparam int CFG_CLK_SRC_BIT = 5;
	localparam int CFG_EDGE_BIT = 4;
	localparam int CFG_ASSIGN_BIT = 3;
	localparam int CFG_RATE_LSB = 0;

	// Comparator control fields
	localparam int CMP_OUT_BIT = 7;
	localparam int CMP_OUTEN_BIT = 6;
	localparam int CMP_TSRC_BIT = 4;

	localparam logic [7:0] CFG_RESET = 8'hFF;
	localparam logic [6:0] CMP_RESET = 7'h7F;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] PRE_RESET = 8'h00;
	localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;

	typedef enum {SRC_TIMER, SRC_PIN, SRC_COMP, SRC_NONE} src_t;

endpackage : tmr_pkg

// ===== cycle_divider.sv
`timescale 1ns/100ps
module cycle_divider
	import tmr_pkg::*;
#(
	parameter int DIV = INSTR_DIV_DEFAULT
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	always_comb begin
		nxt_cnt = cnt_ff + CW'(1);
		nxt_tick = 1'b0;
		if (cnt_ff == LAST) begin
			nxt_cnt = '0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;

endmodule : cycle_divider

// ===== prescaler.sv
`timescale 1ns/100ps
module prescaler
	import tmr_pkg::*;
#(
	parameter int W = PRE_WIDTH,
	parameter int RW = RATE_WIDTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic inc,
	input wire logic [RW-1:0] rate,
	output logic tick,
	output logic [W-1:0] value
);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic [W-1:0] mask;

	// ratio two to the rate plus one
	assign mask = W'((32'd2 << rate) - 32'd1);
	// tick when the masked low bits roll over
	assign tick = inc & ~clr & ((cnt_ff & mask) == mask);

	always_comb begin
		nxt_cnt = cnt_ff;
		if (clr) begin
			nxt_cnt = '0;
		end else if (inc) begin
			nxt_cnt = cnt_ff + W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= PRE_RESET;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign value = cnt_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	localparam int EW = W + 1;

	logic [EW-1:0] evt_ff;
	logic [EW-1:0] nxt_evt;
	logic evt_ok_ff;
	logic nxt_evt_ok;
	logic [RW-1:0] rate_ff;

	// Events since last tick, trusted only under a settled rate
	always_comb begin
		nxt_evt = evt_ff;
		nxt_evt_ok = evt_ok_ff;
		if (rate != rate_ff) begin
			nxt_evt = '0;
			nxt_evt_ok = 1'b0;
		end else if (clr || tick) begin
			nxt_evt = '0;
			nxt_evt_ok = 1'b1;
		end else if (inc) begin
			nxt_evt = evt_ff + EW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_ff <= '0;
			evt_ok_ff <= 1'b0;
			rate_ff <= '0;
		end else begin
			evt_ff <= nxt_evt;
			evt_ok_ff <= nxt_evt_ok;
			rate_ff <= rate;
		end
	end

	property p_ratio;
		@(posedge clk) disable iff (!rst_n)
		tick && evt_ok_ff && (rate == rate_ff) |-> (evt_ff == (EW'(2) << rate) - EW'(1));
	endproperty
	a_ratio: assert property (p_ratio) else $error("prescaler tick off ratio");

endmodule : prescaler

// ===== timer_counter_top.sv
`timescale 1ns/100ps
module timer_counter_top
	import tmr_pkg::*;
#(
	parameter int INSTR_DIV = INSTR_DIV_DEFAULT
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic EXT_COUNT_IN,
	input wire logic COMP_OUT_IN,
	input wire logic WDT_CLOCK_IN,
	input wire logic WDT_CLEAR_IN,
	output logic [7:0] COUNT_VALUE,
	output logic COUNT_WRAP,
	output logic WDT_POST_TICK
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic ack_ff;
	logic nxt_ack;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic [7:0] cfg_ff;
	logic [7:0] nxt_cfg;
	logic [6:0] cmp_ctrl_ff;
	logic [6:0] nxt_cmp_ctrl;
	logic pin_d_ff;
	logic comp_d_ff;
	logic [7:0] count_ff;
	logic [7:0] nxt_count;
	logic [1:0] inhibit_ff;
	logic [1:0] nxt_inhibit;
	logic wrap_ff;
	logic nxt_wrap;
	logic wdt_ff;
	logic nxt_wdt;

	logic wb_req;
	logic [5:0] idx;
	logic wr_fire;
	logic wr_count;
	logic wr_cmp;
	logic wr_cfg;
	logic [7:0] wdat_low;
	logic cycle_en;
	src_t src;
	logic pin_edge;
	logic comp_edge;
	logic src_evt;
	logic assign_wdt;
	logic pre_inc;
	logic pre_clr;
	logic pre_tick;
	logic [7:0] pre_value;
	logic count_step;
	logic inc;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	assign wb_req = WB_CYC_I & WB_STB_I;
	assign idx = WB_ADR_I[7:2];
	assign wdat_low = WB_DAT_I[7:0];
	// Writes land on the edge where the master samples ack
	assign wr_fire = wb_req & WB_WE_I & ack_ff & WB_SEL_I[0];
	assign wr_count = wr_fire & (idx == IDX_COUNT);
	assign wr_cmp = wr_fire & (idx == IDX_CMP_CTRL);
	assign wr_cfg = wr_fire & (idx == IDX_CONFIG);

	always_comb begin
		nxt_ack = wb_req & ~ack_ff;
		nxt_dat = dat_ff;
		if (wb_req & ~ack_ff) begin
			nxt_dat = 32'h00000000;
			if (!WB_WE_I) begin
				// prescaler count never on the read mux
				unique case (idx)
					IDX_COUNT: nxt_dat = {24'h000000, count_ff};
					IDX_CMP_CTRL: nxt_dat = {24'h000000, comp_d_ff, cmp_ctrl_ff};
					default: nxt_dat = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h00000000;
		end else begin
			ack_ff <= nxt_ack;
			dat_ff <= nxt_dat;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_cmp_ctrl = cmp_ctrl_ff;
		if (wr_cfg) begin
			nxt_cfg = wdat_low;
		end
		if (wr_cmp) begin
			nxt_cmp_ctrl = wdat_low[6:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_ff <= CFG_RESET;
			cmp_ctrl_ff <= CMP_RESET;
		end else begin
			cfg_ff <= nxt_cfg;
			cmp_ctrl_ff <= nxt_cmp_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Count source selection

	cycle_divider #(
		.DIV(INSTR_DIV)
	) u_div (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.tick(cycle_en)
	);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_d_ff <= 1'b0;
			comp_d_ff <= 1'b0;
		end else begin
			pin_d_ff <= EXT_COUNT_IN;
			comp_d_ff <= COMP_OUT_IN;
		end
	end

	// edge select picks rising or falling
	assign pin_edge = cfg_ff[CFG_EDGE_BIT] ? (pin_d_ff & ~EXT_COUNT_IN)
		: (EXT_COUNT_IN & ~pin_d_ff);
	assign comp_edge = COMP_OUT_IN & ~comp_d_ff;

	always_comb begin
		if (!cfg_ff[CFG_CLK_SRC_BIT]) begin
			src = SRC_TIMER;
		end else if (!cmp_ctrl_ff[CMP_TSRC_BIT]) begin
			src = SRC_COMP;
		// pin needs both comparator bits set
		end else if (cmp_ctrl_ff[CMP_OUTEN_BIT]) begin
			src = SRC_PIN;
		end else begin
			src = SRC_NONE;
		end
	end

	always_comb begin
		unique case (src)
			SRC_TIMER: src_evt = cycle_en;
			SRC_PIN: src_evt = pin_edge;
			SRC_COMP: src_evt = comp_edge;
			SRC_NONE: src_evt = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler routing

	assign assign_wdt = cfg_ff[CFG_ASSIGN_BIT];
	// assignment bit steers input and clear
	assign pre_inc = assign_wdt ? WDT_CLOCK_IN : src_evt;
	assign pre_clr = assign_wdt ? WDT_CLEAR_IN : wr_count;

	prescaler #(
		.W(PRE_WIDTH),
		.RW(RATE_WIDTH)
	) u_pre (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.clr(pre_clr),
		.inc(pre_inc),
		.rate(cfg_ff[CFG_RATE_LSB +: RATE_WIDTH]),
		.tick(pre_tick),
		.value(pre_value)
	);

	// prescaler output goes one way only
	assign count_step = assign_wdt ? src_evt : pre_tick;
	assign inc = count_step & (inhibit_ff == 2'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Count register

	always_comb begin
		nxt_count = count_ff;
		nxt_inhibit = inhibit_ff;
		nxt_wrap = 1'b0;
		nxt_wdt = assign_wdt & pre_tick;
		if (wr_count) begin
			nxt_count = wdat_low;
			nxt_inhibit = WRITE_INHIBIT_CYCLES;
		end else begin
			if ((inhibit_ff != 2'h0) && cycle_en) begin
				nxt_inhibit = inhibit_ff - 2'h1;
			end
			if (inc) begin
				nxt_count = count_ff + 8'h01;
				nxt_wrap = (count_ff == 8'hFF);
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			count_ff <= COUNT_RESET;
			inhibit_ff <= 2'h0;
			wrap_ff <= 1'b0;
			wdt_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			inhibit_ff <= nxt_inhibit;
			wrap_ff <= nxt_wrap;
			wdt_ff <= nxt_wdt;
		end
	end

	assign WB_ACK_O = ack_ff;
	assign WB_DAT_O = dat_ff;
	assign COUNT_VALUE = count_ff;
	assign COUNT_WRAP = wrap_ff;
	assign WDT_POST_TICK = wdt_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_count_load;
		@(posedge SYS_CLK) disable iff (!RST_N)
		wr_count |=> (count_ff == $past(wdat_low));
	endproperty
	a_count_load: assert property (p_count_load) else $error("count load lost");

	property p_timer_step;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(src == SRC_TIMER) && assign_wdt && (inhibit_ff == 2'h0) && cycle_en && !wr_count
		|=> (count_ff == $past(count_ff) + 8'h01);
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("timer step missed");

	property p_hold_start;
		@(posedge SYS_CLK) disable iff (!RST_N)
		wr_count |=> (inhibit_ff == WRITE_INHIBIT_CYCLES) ##1 $stable(count_ff);
	endproperty
	a_hold_start: assert property (p_hold_start) else $error("hold-off not started");

	property p_hold_freeze;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(inhibit_ff != 2'h0) && !wr_count |=> (count_ff == $past(count_ff));
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("count moved in hold-off");

	property p_pin_rise;
		@(posedge SYS_CLK) disable iff (!RST_N)
		cfg_ff[CFG_CLK_SRC_BIT] && cmp_ctrl_ff[CMP_TSRC_BIT] && cmp_ctrl_ff[CMP_OUTEN_BIT]
		&& !cfg_ff[CFG_EDGE_BIT] && EXT_COUNT_IN && !pin_d_ff |-> src_evt;
	endproperty
	a_pin_rise: assert property (p_pin_rise) else $error("pin rise not counted");

	property p_comp_src;
		@(posedge SYS_CLK) disable iff (!RST_N)
		cfg_ff[CFG_CLK_SRC_BIT] && !cmp_ctrl_ff[CMP_TSRC_BIT] && COMP_OUT_IN && !comp_d_ff
		|-> src_evt;
	endproperty
	a_comp_src: assert property (p_comp_src) else $error("comparator edge missed");

	property p_one_owner;
		@(posedge SYS_CLK) disable iff (!RST_N)
		WDT_POST_TICK |-> $past(assign_wdt);
	endproperty
	a_one_owner: assert property (p_one_owner) else $error("watchdog tick while unassigned");

	property p_pre_clear;
		@(posedge SYS_CLK) disable iff (!RST_N)
		wr_count && !assign_wdt |=> (pre_value == 8'h00);
	endproperty
	a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

	property p_wrap;
		@(posedge SYS_CLK) disable iff (!RST_N)
		inc && (count_ff == 8'hFF) && !wr_count |=> (count_ff == 8'h00) && COUNT_WRAP;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap");

endmodule : timer_counter_top

// ===== count_source_model.sv
`timescale 1ns/100ps
module count_source_model (
	input wire logic clk,
	output logic pin,
	output logic comp
);
	initial begin
		pin = 1'b0;
		comp = 1'b0;
	end
	// Drive the pin to a level and hold it
	task automatic set_pin(input logic lvl);
		@(posedge clk);
		pin <= lvl;
		repeat (2) @(posedge clk);
	endtask : set_pin
	// Full pulses, two clocks high and two low
	task automatic pulse(input int n, input logic use_comp);
		repeat (n) begin
			@(posedge clk);
			if (use_comp) begin
				comp <= 1'b1;
			end else begin
				pin <= 1'b1;
			end
			repeat (2) @(posedge clk);
			comp <= 1'b0;
			pin <= 1'b0;
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
	endtask : pulse
endmodule : count_source_model

// ===== test_timer_counter_with_prescaler.sv
`timescale 1ns/100ps
module test_timer_counter_with_prescaler;
	localparam logic [7:0] A_CNT = {tmr_pkg::IDX_COUNT, 2'b00};
	localparam logic [7:0] A_CMP = {tmr_pkg::IDX_CMP_CTRL, 2'b00};
	localparam logic [7:0] A_CFG = {tmr_pkg::IDX_CONFIG, 2'b00};
	localparam logic [7:0] A_UNM = 8'h3C;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic wdt_clk = 1'b0;
	logic wdt_clr = 1'b0;
	logic [31:0] dat_o;
	logic ack, wrap, post, pin, comp;
	logic [7:0] count_value;
	logic [7:0] v;
	int err_count = 0;
	int samples_checked = 0;
	int wraps = 0;
	int posts = 0;
	logic [31:0] exp_q[$];

	always #20 sys_clk = ~sys_clk;

	timer_counter_top #(.INSTR_DIV(1)) u_dut (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .EXT_COUNT_IN(pin), .COMP_OUT_IN(comp),
		.WDT_CLOCK_IN(wdt_clk), .WDT_CLEAR_IN(wdt_clr), .COUNT_VALUE(count_value),
		.COUNT_WRAP(wrap), .WDT_POST_TICK(post)
	);
	count_source_model u_src (.clk(sys_clk), .pin(pin), .comp(comp));

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
		int n;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		sel <= s;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			test_done();
		end else begin
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
		end
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		wb(a, 1'b0, 8'h00, 4'hF);
	endtask : rd

	task automatic wdt_pulse(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			wdt_clk <= 1'b1;
			@(posedge sys_clk);
			wdt_clk <= 1'b0;
		end
		repeat (3) @(posedge sys_clk);
	endtask : wdt_pulse

	function automatic logic [7:0] cfg(input logic cs, input logic e, input logic asg,
		input logic [2:0] r);
		return {2'b00, cs, e, asg, r};
	endfunction : cfg

	////////////////////////////////////////////////////////////////
	// Read data scoreboard and pulse counters
	always @(posedge sys_clk) begin
		if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
			check(dat_o, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFFFFFF);
		end
		if (wrap === 1'b1) wraps++;
		if (post === 1'b1) posts++;
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		void'($urandom(32'hF118));
		@(posedge sys_clk);
		#1 check(count_value, 8'h00);
		rd(A_CFG, 8'h00);
		rd(A_CMP, 8'h7F);
		rd(A_UNM, 8'h00);
		v = 8'($urandom);
		wb(A_CNT, 1'b1, v, 4'hF);
		rd(A_CNT, v);
		wb(A_CNT, 1'b1, ~v, 4'hE);
		rd(A_CNT, v);
		for (int e = 0; e < 2; e++) begin
			wb(A_CFG, 1'b1, cfg(1'b1, e[0], 1'b1, 3'h7), 4'hF);
			wb(A_CNT, 1'b1, 8'h00, 4'hF);
			repeat (3) @(posedge sys_clk);
			u_src.set_pin(1'b1);
			rd(A_CNT, (e == 0) ? 8'h01 : 8'h00);
			u_src.set_pin(1'b0);
			u_src.pulse(4, 1'b0);
			rd(A_CNT, 8'h05);
		end
		for (int o = 0; o < 2; o++) begin
			wb(A_CMP, 1'b1, {1'b0, o[0], 6'h00}, 4'hF);
			wb(A_CNT, 1'b1, 8'h00, 4'hF);
			repeat (3) @(posedge sys_clk);
			u_src.pulse(3, 1'b1);
			u_src.pulse(2, 1'b0);
			rd(A_CNT, 8'h03);
		end
		wb(A_CMP, 1'b1, 8'h10, 4'hF);
		u_src.pulse(2, 1'b0);
		rd(A_CNT, 8'h03);
		wb(A_CMP, 1'b1, 8'h50, 4'hF);
		rd(A_CMP, 8'h50);
		for (int r = 0; r < 8; r++) begin
			wb(A_CFG, 1'b1, cfg(1'b1, 1'b1, 1'b0, r[2:0]), 4'hF);
			u_src.pulse(1 + $urandom % 3, 1'b0);
			wb(A_CNT, 1'b1, 8'h00, 4'hF);
			repeat (3) @(posedge sys_clk);
			u_src.pulse(3 * (2 << r) - 1, 1'b0);
			rd(A_CNT, 8'h02);
		end
		wb(A_CFG, 1'b1, cfg(1'b1, 1'b1, 1'b1, 3'h7), 4'hF);
		wb(A_CNT, 1'b1, 8'hFF, 4'hF);
		repeat (3) @(posedge sys_clk);
		wraps = 0;
		u_src.pulse(1, 1'b0);
		rd(A_CNT, 8'h00);
		check(wraps, 1);
		wb(A_CFG, 1'b1, cfg(1'b1, 1'b1, 1'b1, 3'h0), 4'hF);
		@(posedge sys_clk);
		wdt_clr <= 1'b1;
		@(posedge sys_clk);
		wdt_clr <= 1'b0;
		posts = 0;
		wdt_pulse(6);
		check(posts, 3);
		wb(A_CFG, 1'b1, cfg(1'b1, 1'b1, 1'b0, 3'h0), 4'hF);
		posts = 0;
		wdt_pulse(6);
		check(posts, 0);
		wb(A_CFG, 1'b1, cfg(1'b0, 1'b0, 1'b1, 3'h0), 4'hF);
		repeat (4) @(posedge sys_clk);
		wb(A_CNT, 1'b1, 8'h40, 4'hF);
		repeat (2) @(posedge sys_clk);
		#1 check(count_value, 8'h40);
		repeat (8) @(posedge sys_clk);
		#1 v = count_value;
		repeat (10) @(posedge sys_clk);
		#1 check(count_value, 8'(v + 8'h0A));
		wb(A_CFG, 1'b1, cfg(1'b0, 1'b0, 1'b0, 3'h0), 4'hF);
		repeat (4) @(posedge sys_clk);
		#1 v = count_value;
		repeat (16) @(posedge sys_clk);
		#1 check(count_value, 8'(v + 8'h08));
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1 check(count_value, 8'h00);
		rd(A_CMP, 8'h7F);
		repeat (4) @(posedge sys_clk);
		check(exp_q.size(), 0);
		test_done();
	end
endmodule : test_timer_counter_with_prescaler
